// ### src/rtc_calendar_register_bank.sv
`timescale 1ns/10ps
module rtc_calendar_register_bank
    import rtc_pkg::*;
#(
    parameter int unsigned SIXTEENTH_COUNT = SIXTEENTH_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    output logic             irq
);
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = v + 8'h01;
        end
    endfunction : bcd_inc

    function automatic logic [7:0] last_day(input logic [7:0] m, input logic leap);
        case (m)
            8'h02:                      last_day = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default:                    last_day = 8'h31;
        endcase
    endfunction : last_day

    // carries one minute into hours, days, months and years
    function automatic calendar_t add_minute(input calendar_t c, input logic h24,
                                             input logic leap);
        calendar_t n;
        logic      day;
        n   = c;
        day = 1'b0;
        if (c.min != 8'h59) begin
            n.min = bcd_inc(c.min);
        end else begin
            n.min = 8'h00;
            if (h24) begin
                if (c.hour == 8'h23) begin
                    n.hour = 8'h00;
                    day    = 1'b1;
                end else begin
                    n.hour = bcd_inc(c.hour);
                end
            end else if (c.hour[4:0] == 5'h11) begin
                n.hour = c.hour[5] ? 8'h00 : 8'h20;
                day    = c.hour[5];
            end else begin
                n.hour = bcd_inc(c.hour);
            end
        end
        if (day) begin
            n.wday = (c.wday == 8'h06) ? 8'h00 : c.wday + 8'h01;
            if (c.date == last_day(c.month, leap)) begin
                n.date = 8'h01;
                if (c.month == 8'h12) begin
                    n.month = 8'h01;
                    n.year  = (c.year == 8'h99) ? 8'h00 : bcd_inc(c.year);
                end else begin
                    n.month = bcd_inc(c.month);
                end
            end else begin
                n.date = bcd_inc(c.date);
            end
        end
        add_minute = n;
    endfunction : add_minute

    bus_req_t    dp;
    logic        rd_wait;
    logic        accept;
    logic        wr;
    logic [7:0]  wd;
    logic [7:0]  page;
    logic [7:0]  clear;
    logic [2:0]  status;
    logic [2:0]  enable;
    logic [2:0]  events;
    calendar_t   cal;
    calendar_t   next_cal;
    logic [7:0]  al_min;
    logic [7:0]  al_hour;
    logic [7:0]  al_wday;
    logic [7:0]  al_date;
    logic        hour24;
    logic [1:0]  leap;
    logic [31:0] sub_cnt;
    logic [3:0]  sixteenth;
    logic        tick16;
    logic        sec_step;
    logic        correct_step;
    logic        cal_step;
    logic        alarm_hit;
    logic [7:0]  read_value;

    assign accept    = hsel && htrans[1] && hready;
    assign wr        = dp.valid && dp.write && dp.mapped;
    assign wd        = hwdata[7:0];
    assign hreadyout = !rd_wait;
    assign hresp     = 1'b0;

    // address phase is held through the read wait state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dp <= '0;
        end else if (hready) begin
            dp.valid  <= accept && (hsize == 3'b010);
            dp.write  <= hwrite;
            dp.mapped <= (haddr[31:7] == 25'h000_0000);
            dp.idx    <= haddr[6:2];
        end
    end

    // one wait state on reads so a write just before is visible
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rd_wait <= 1'b0;
            hrdata  <= 32'h0000_0000;
        end else begin
            rd_wait <= accept && !hwrite && (hsize == 3'b010);
            if (rd_wait) begin
                hrdata <= {24'h00_0000, read_value};
            end
        end
    end

    always_comb begin
        read_value = 8'h00;
        if (dp.mapped) begin
            case (dp.idx)
                IDX_SEC:        read_value = page[PAGE_SEL_BIT] ? 8'h00 : cal.sec;
                IDX_MIN:        read_value = page[PAGE_SEL_BIT] ? al_min : cal.min;
                IDX_HOUR:       read_value = page[PAGE_SEL_BIT] ? al_hour : cal.hour;
                IDX_WDAY:       read_value = page[PAGE_SEL_BIT] ? al_wday : cal.wday;
                IDX_DATE:       read_value = page[PAGE_SEL_BIT] ? al_date : cal.date;
                IDX_MONTH:      read_value = page[PAGE_SEL_BIT] ? {7'h00, hour24} : cal.month;
                IDX_YEAR:       read_value = page[PAGE_SEL_BIT] ? {6'h00, leap} : cal.year;
                IDX_PAGE:       read_value = page;
                IDX_CLEAR:      read_value = clear;
                IDX_IRQ_STATUS: read_value = {5'h00, status};
                IDX_IRQ_ENABLE: read_value = {5'h00, enable};
                default:        read_value = 8'h00;
            endcase
        end
    end

    // correction requests self-clear once acted on; alarm and clock clear bits self-clear the cycle after they are set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            page  <= PAGE_RESET;
            clear <= CLEAR_RESET;
        end else begin
            if (wr && dp.idx == IDX_PAGE) begin
                page <= wd & PAGE_MASK;
            end else if (correct_step) begin
                page[CORRECT_BIT] <= 1'b0;
            end
            if (wr && dp.idx == IDX_CLEAR) begin
                clear <= wd & CLEAR_MASK;
            end else begin
                clear[ALARM_CLR_BIT] <= 1'b0;
                clear[CLOCK_CLR_BIT] <= 1'b0;
            end
        end
    end

    // prescaler: one sixteenth-second enable, sixteen of them per second
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sub_cnt   <= 32'h0000_0000;
            sixteenth <= 4'h0;
        end else if (clear[CLOCK_CLR_BIT] || !page[CLOCK_EN_BIT]) begin
            sub_cnt   <= 32'h0000_0000;
            sixteenth <= clear[CLOCK_CLR_BIT] ? 4'h0 : sixteenth;
        end else if (tick16) begin
            sub_cnt   <= 32'h0000_0000;
            sixteenth <= sixteenth + 4'h1;
        end else begin
            sub_cnt <= sub_cnt + 32'h0000_0001;
        end
    end

    assign tick16       = page[CLOCK_EN_BIT] && !clear[CLOCK_CLR_BIT]
                          && (sub_cnt == SIXTEENTH_COUNT - 1);
    assign sec_step     = tick16 && (sixteenth == 4'hF);
    assign correct_step = page[CORRECT_BIT] && !sec_step;
    assign cal_step     = sec_step || correct_step;

    always_comb begin
        next_cal = cal;
        if (sec_step) begin
            if (cal.sec == 8'h59) begin
                next_cal     = add_minute(cal, hour24, leap == 2'd0);
                next_cal.sec = 8'h00;
            end else begin
                next_cal.sec = bcd_inc(cal.sec);
            end
        end else if (correct_step) begin
            // thirty or more rounds up to the next minute
            if (cal.sec >= 8'h30) begin
                next_cal = add_minute(cal, hour24, leap == 2'd0);
            end
            next_cal.sec = 8'h00;
        end
    end

    assign alarm_hit = page[ALARM_EN_BIT] && cal_step && (next_cal.sec == 8'h00)
                       && (next_cal.min != cal.min) && (next_cal.min == al_min)
                       && (next_cal.hour == al_hour) && (next_cal.wday == al_wday)
                       && (next_cal.date == al_date);

    // no reset: counted values survive a system reset
    always_ff @(posedge clock) begin
        if (wr && !page[PAGE_SEL_BIT]) begin
            cal <= next_cal;
            case (dp.idx)
                IDX_SEC:   cal.sec   <= wd & SEC_MASK;
                IDX_MIN:   cal.min   <= wd & MIN_MASK;
                IDX_HOUR:  cal.hour  <= wd & HOUR_MASK;
                IDX_WDAY:  cal.wday  <= wd & WDAY_MASK;
                IDX_DATE:  cal.date  <= wd & DATE_MASK;
                IDX_MONTH: cal.month <= wd & MONTH_MASK;
                IDX_YEAR:  cal.year  <= wd;
                default:   cal       <= next_cal;
            endcase
        end else begin
            cal <= next_cal;
        end
    end

    always_ff @(posedge clock) begin
        if (wr && page[PAGE_SEL_BIT]) begin
            case (dp.idx)
                IDX_MIN:   al_min  <= wd & MIN_MASK;
                IDX_HOUR:  al_hour <= wd & HOUR_MASK;
                IDX_WDAY:  al_wday <= wd & WDAY_MASK;
                IDX_DATE:  al_date <= wd & DATE_MASK;
                IDX_MONTH: hour24  <= wd[0];
                default:   al_min  <= al_min;
            endcase
        end
        if (wr && page[PAGE_SEL_BIT] && dp.idx == IDX_YEAR) begin
            leap <= wd[1:0];
        end else if (cal_step && next_cal.year != cal.year) begin
            leap <= leap + 2'd1;
        end
    end

    assign events = {tick16 && !clear[SIXTEEN_OFF_BIT], alarm_hit,
                     sec_step && !clear[ONE_HZ_OFF_BIT]};

    // a new event in the clearing cycle stays set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status <= IRQ_RESET;
            enable <= IRQ_RESET;
        end else begin
            if (wr && dp.idx == IDX_IRQ_CLEAR) begin
                status <= (status & ~wd[2:0]) | events;
            end else if (clear[ALARM_CLR_BIT]) begin
                status <= (status & 3'b101) | events;
            end else begin
                status <= status | events;
            end
            if (wr && dp.idx == IDX_IRQ_ENABLE) begin
                enable <= wd[2:0];
            end
        end
    end

    assign irq = page[IRQ_GATE_BIT] && |(status & enable);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    reset_init_a: assert property ($rose(rst_n) |-> page == PAGE_RESET
        && clear == CLEAR_RESET) else $error("control fields not initialised");
    live_read_a: assert property (rd_wait && dp.idx == IDX_MIN && dp.mapped
        && !page[PAGE_SEL_BIT] |=> hrdata[7:0] == $past(cal.min))
        else $error("clock page read not live");
    alarm_read_a: assert property (rd_wait && dp.idx == IDX_YEAR && dp.mapped
        && page[PAGE_SEL_BIT] |=> hrdata[7:0] == {6'h00, $past(leap)})
        else $error("alarm page read wrong");
    sec_bit7_a: assert property (rd_wait && dp.idx == IDX_SEC
        |=> hrdata[31:7] == 25'h000_0000) else $error("seconds upper bits set");
    page_steer_a: assert property (wr && page[PAGE_SEL_BIT] && dp.idx == IDX_MIN
        |=> cal.min == $past(next_cal.min)) else $error("alarm write hit clock");
    year_wrap_a: assert property (cal_step && cal.year == 8'h99
        && next_cal.year != cal.year |-> next_cal.year == 8'h00)
        else $error("year did not wrap");
    leap_feb_a: assert property (cal_step && cal.month == 8'h02 && cal.date == 8'h29
        && next_cal.date != cal.date |-> leap == 2'd0 && next_cal.date == 8'h01)
        else $error("february 29 outside leap year");
    pm_flag_a: assert property (cal_step && !hour24 && cal.hour == 8'h11
        && next_cal.hour != cal.hour |-> next_cal.hour == 8'h20)
        else $error("noon did not set pm");
    read_wait_a: assert property (accept && !hwrite && hsize == 3'b010
        |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    irq_level_a: assert property (page[IRQ_GATE_BIT] && |(events & enable) |=> irq)
        else $error("enabled event gave no interrupt");

    read_clock_c: cover property (rd_wait && !page[PAGE_SEL_BIT] && dp.idx == IDX_SEC);
    alarm_hit_c: cover property (alarm_hit);
    correct_c: cover property (correct_step && cal.sec >= 8'h30);
endmodule : rtc_calendar_register_bank

// ### src/rtc_pkg.sv
package rtc_pkg;
    // register indices; byte address is four times the index
    localparam logic [4:0] IDX_SEC        = 5'h00;
    localparam logic [4:0] IDX_MIN        = 5'h01;
    localparam logic [4:0] IDX_HOUR       = 5'h02;
    localparam logic [4:0] IDX_WDAY       = 5'h04;
    localparam logic [4:0] IDX_DATE       = 5'h05;
    localparam logic [4:0] IDX_MONTH      = 5'h06;
    localparam logic [4:0] IDX_YEAR       = 5'h07;
    localparam logic [4:0] IDX_PAGE       = 5'h08;
    localparam logic [4:0] IDX_CLEAR      = 5'h0C;
    localparam logic [4:0] IDX_IRQ_STATUS = 5'h10;
    localparam logic [4:0] IDX_IRQ_CLEAR  = 5'h11;
    localparam logic [4:0] IDX_IRQ_ENABLE = 5'h12;

    localparam int PAGE_SEL_BIT    = 0;
    localparam int ALARM_EN_BIT    = 2;
    localparam int CLOCK_EN_BIT    = 3;
    localparam int CORRECT_BIT     = 4;
    localparam int IRQ_GATE_BIT    = 7;
    localparam int ALARM_CLR_BIT   = 4;
    localparam int CLOCK_CLR_BIT   = 5;
    localparam int SIXTEEN_OFF_BIT = 6;
    localparam int ONE_HZ_OFF_BIT  = 7;

    localparam logic [7:0] PAGE_RESET  = 8'h00;
    localparam logic [7:0] CLEAR_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET   = 3'h0;

    localparam logic [7:0] SEC_MASK   = 8'h7F;
    localparam logic [7:0] MIN_MASK   = 8'h7F;
    localparam logic [7:0] HOUR_MASK  = 8'h3F;
    localparam logic [7:0] WDAY_MASK  = 8'h07;
    localparam logic [7:0] DATE_MASK  = 8'h3F;
    localparam logic [7:0] MONTH_MASK = 8'h1F;
    localparam logic [7:0] PAGE_MASK  = 8'h9D;
    localparam logic [7:0] CLEAR_MASK = 8'hF0;

    localparam int EV_SECOND  = 0;
    localparam int EV_ALARM   = 1;
    localparam int EV_SIXTEEN = 2;

    localparam int CLOCK_PERIOD_NS   = 100;
    localparam int SIXTEENTH_NS      = 62_500_000;
    localparam int SIXTEENTH_CYCLES  = SIXTEENTH_NS / CLOCK_PERIOD_NS;

    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] wday;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } calendar_t;

    typedef struct packed {
        logic       valid;
        logic       write;
        logic       mapped;
        logic [4:0] idx;
    } bus_req_t;
endpackage : rtc_pkg

// ### verif/rtc_calendar_register_bank_tb.sv
`timescale 1ns/10ps
module rtc_calendar_register_bank_tb;
    import rtc_pkg::*;

    localparam int unsigned TICK = 4;

    logic        clock;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        irq;
    int          mismatches;
    int          compares;
    integer      seed;
    logic [31:0] rdv;

    rtc_calendar_register_bank #(.SIXTEENTH_COUNT(TICK)) rtc_calendar_register_bank_inst (
        .clock     (clock),
        .rst_n     (rst_n),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .irq       (irq)
    );

    always #50 clock = ~clock;

    function automatic logic [31:0] addr_of(input logic [4:0] idx);
        return {25'h000_0000, idx, 2'b00};
    endfunction : addr_of

    // one bcd step of a field, wrapping from top to low
    function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
                                            input logic [7:0] low);
        if (v == top) return low;
        if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
        return v + 8'h01;
    endfunction : bcd_step

    // twelve-hour mode: 11 am goes to pm 0, pm 11 goes to am 0
    function automatic logic [7:0] hour_step(input logic fmt, input logic [7:0] h);
        if (fmt) return bcd_step(h, 8'h23, 8'h00);
        if (h[4:0] == 5'h11) return h[5] ? 8'h00 : 8'h20;
        return {h[7:5], bcd_step({3'b000, h[4:0]}, 8'h11, 8'h00)};
    endfunction : hour_step

    // last day of a month; leap state 0 marks the year that is divisible by four
    function automatic logic [7:0] month_end(input logic [7:0] mo, input logic [1:0] lp);
        if (mo == 8'h02) return (lp == 2'd0) ? 8'h29 : 8'h28;
        if (mo == 8'h04 || mo == 8'h06 || mo == 8'h09 || mo == 8'h11) return 8'h30;
        return 8'h31;
    endfunction : month_end

    task automatic stop_test;
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // address phase held until hready, then data phase held until hready again
    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] wd,
                        output logic [31:0] rd);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize  <= 3'b010;
        // no cycle count is assumed; a hung slave is left to the watchdog
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, wd};
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [4:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        xfer(1'b1, addr_of(idx), d, unused);
    endtask : wr

    // every register is read twice, as software must to reject a torn capture
    task automatic rd_check(input string what, input logic [4:0] idx, input logic [7:0] exp);
        logic [31:0] v;
        repeat (2) begin
            xfer(1'b0, addr_of(idx), 8'h00, v);
            check(what, {24'h00_0000, exp}, v);
        end
    endtask : rd_check

    // load a calendar with the clock held, run one and a half seconds (24 ticks), then freeze it
    task automatic one_step(input logic fmt, input logic [7:0] hr, input logic [7:0] dt,
                            input logic [7:0] mo, input logic [7:0] yr, input logic [1:0] lp);
        logic new_day;
        logic new_month;
        logic new_year;
        new_day   = fmt ? (hr == 8'h23) : (hr == 8'h31);
        new_month = new_day && dt == month_end(mo, lp);
        new_year  = new_month && mo == 8'h12;
        wr(IDX_PAGE, 8'h01);
        wr(IDX_MONTH, {7'h00, fmt});
        wr(IDX_YEAR, {6'h00, lp});
        wr(IDX_PAGE, 8'h80);
        wr(IDX_SEC, 8'h59);
        wr(IDX_MIN, 8'h59);
        wr(IDX_HOUR, hr);
        wr(IDX_WDAY, 8'h06);
        wr(IDX_DATE, dt);
        wr(IDX_MONTH, mo);
        wr(IDX_YEAR, yr);
        wr(IDX_IRQ_ENABLE, 8'h01);
        // sixteenth ticks are silenced so only the one-second event reaches status
        wr(IDX_CLEAR, 8'h60);
        wr(IDX_PAGE, 8'h88);
        // one second is 16 ticks; stop between the first and second step
        repeat (24 * TICK) @(posedge clock);
        wr(IDX_PAGE, 8'h80);
        rd_check("sec", IDX_SEC, 8'h00);
        rd_check("min", IDX_MIN, 8'h00);
        rd_check("hour", IDX_HOUR, hour_step(fmt, hr));
        rd_check("wday", IDX_WDAY, new_day ? 8'h00 : 8'h06);
        rd_check("date", IDX_DATE, new_day ? bcd_step(dt, month_end(mo, lp), 8'h01) : dt);
        rd_check("month", IDX_MONTH, new_month ? bcd_step(mo, 8'h12, 8'h01) : mo);
        rd_check("year", IDX_YEAR, new_year ? bcd_step(yr, 8'h99, 8'h00) : yr);
        check("irq set", 32'h0000_0001, {31'h0000_0000, irq});
        rd_check("status", IDX_IRQ_STATUS, 8'h01);
        wr(IDX_IRQ_CLEAR, 8'h01);
        // the clear lands on the edge the write returns at; look once it has settled
        @(posedge clock);
        check("irq clear", 32'h0000_0000, {31'h0000_0000, irq});
        wr(IDX_IRQ_ENABLE, 8'h00);
        wr(IDX_PAGE, 8'h01);
        rd_check("leap", IDX_YEAR, {6'h00, new_year ? lp + 2'd1 : lp});
    endtask : one_step

    initial begin
        logic [7:0] s;
        clock = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0000_0000;
        mismatches = 0;
        compares = 0;
        seed = 32'h2dc3;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        rd_check("page rst", IDX_PAGE, PAGE_RESET);
        rd_check("clear rst", IDX_CLEAR, CLEAR_RESET);
        check("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
        for (int i = 0; i < 8; i++) begin
            s = {1'b0, 3'(($random(seed) & 32'h7fff_ffff) % 6),
                 4'(($random(seed) & 32'h7fff_ffff) % 10)};
            wr(IDX_SEC, s);
            rd_check("sec rand", IDX_SEC, s);
        end
        rd_check("hole", 5'h03, 8'h00);
        xfer(1'b0, 32'h0000_0100, 8'h00, rdv);
        check("high addr", 32'h0000_0000, rdv);
        wr(IDX_CLEAR, 8'h0F);
        rd_check("clear low", IDX_CLEAR, 8'h00);
        wr(IDX_PAGE, 8'h6E);
        rd_check("page clk", IDX_PAGE, 8'h0C);
        wr(IDX_PAGE, 8'h6F);
        rd_check("page alm", IDX_PAGE, 8'h0D);
        wr(IDX_PAGE, 8'h00);
        wr(IDX_MIN, 8'h12);
        wr(IDX_PAGE, 8'h01);
        rd_check("alm sec", IDX_SEC, 8'h00);
        wr(IDX_MIN, 8'h45);
        rd_check("alm min", IDX_MIN, 8'h45);
        wr(IDX_PAGE, 8'h00);
        rd_check("clk min", IDX_MIN, 8'h12);
        wr(IDX_SEC, 8'h42);
        wr(IDX_CLEAR, 8'hC0);
        wr(IDX_PAGE, 8'h01);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_check("page rst2", IDX_PAGE, PAGE_RESET);
        rd_check("clear rst2", IDX_CLEAR, CLEAR_RESET);
        rd_check("sec kept", IDX_SEC, 8'h42);
        rd_check("min kept", IDX_MIN, 8'h12);
        // forty-two seconds rounds up to the next minute with the clock held
        wr(IDX_PAGE, 8'h10);
        rd_check("adj page", IDX_PAGE, 8'h00);
        rd_check("adj sec", IDX_SEC, 8'h00);
        rd_check("adj min", IDX_MIN, 8'h13);
        one_step(1'b1, 8'h23, 8'h31, 8'h12, 8'h99, 2'd3);
        one_step(1'b0, 8'h11, 8'h10, 8'h05, 8'h24, 2'd0);
        one_step(1'b0, 8'h31, 8'h10, 8'h05, 8'h24, 2'd0);
        one_step(1'b1, 8'h23, 8'h29, 8'h02, 8'h24, 2'd0);
        one_step(1'b1, 8'h23, 8'h28, 8'h02, 8'h23, 2'd3);
        stop_test();
    end

    // the whole sequence needs well under 10000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        stop_test();
    end
endmodule : rtc_calendar_register_bank_tb
